//--- src/pfm_pin_mux.sv
// Primary pin function multiplexer with its classic Wishbone register slave.
//
// Local design decisions: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
module pfm_pin_mux (
  // Clock, reset and freeze.
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // Default-return events, one-cycle pulses on core_clk.
  input  wire logic        runtime_reset,
  input  wire logic        sleep_entry,
  // Wishbone classic slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Primary general-purpose pins.
  input  wire logic [31:0] pad_gpio_i,
  output logic      [31:0] pad_gpio_o,
  output logic      [31:0] pad_gpio_oe,
  // Synchronised primary inputs for the interrupt controllers.
  output logic      [31:0] gpio_in_level,
  // Secondary block lines 200..215.
  input  wire logic [15:0] sec_gpio_do,
  input  wire logic [15:0] sec_gpio_dir,
  output logic      [15:0] sec_gpio_di,
  // Card interface pins and strobes.
  input  wire logic [3:0]  pad_card_i,
  output logic      [3:0]  pad_card_o,
  output logic      [3:0]  pad_card_oe,
  input  wire logic        card_attr_strobe_n,
  input  wire logic        card_enable_low_n,
  input  wire logic        card_enable_high_n,
  input  wire logic        card_write_strobe_n,
  // External display pins and strobes.
  input  wire logic [3:0]  pad_disp_i,
  output logic      [3:0]  pad_disp_o,
  output logic      [3:0]  pad_disp_oe,
  input  wire logic        ext_disp_read0,
  input  wire logic        ext_disp_read1,
  input  wire logic        ext_disp_write0,
  input  wire logic        ext_disp_write1,
  // Serial transmit pins.
  input  wire logic        pad_u3_i,
  output logic             pad_u3_o,
  output logic             pad_u3_oe,
  input  wire logic        third_serial_tx,
  input  wire logic        pad_u1_i,
  output logic             pad_u1_o,
  output logic             pad_u1_oe,
  input  wire logic        second_serial_tx,
  // USB pin pair, bit 1 plus and bit 0 minus.
  input  wire logic [1:0]  pad_usb_i,
  output logic      [1:0]  pad_usb_o,
  output logic      [1:0]  pad_usb_oe,
  input  wire logic [1:0]  device_port_o,
  input  wire logic [1:0]  device_port_oe,
  output logic      [1:0]  device_port_i,
  input  wire logic [1:0]  host0_o,
  input  wire logic [1:0]  host0_oe,
  output logic      [1:0]  host0_i,
  // Peripheral sources for the primary shared pins.
  input  wire logic        sync_rom_clk_enable,
  input  wire logic        aux_clock_out0,
  input  wire logic        osc32k_clk
);

  // Complete state of the block.
  typedef struct packed {
    logic [31:0] pinfunc;
    logic [31:0] gpio_out;
    logic [31:0] gpio_dir;
    logic [31:0] gin_s1;
    logic [31:0] gin_s2;
    logic [15:0] sin_s1;
    logic [15:0] sin_s2;
    logic [1:0]  usb_s1;
    logic [1:0]  usb_s2;
    logic        ack;
    logic [31:0] rdata;
    logic [31:0] gpio_o;
    logic [31:0] gpio_oe;
    logic [3:0]  card_o;
    logic [3:0]  card_oe;
    logic [3:0]  disp_o;
    logic [3:0]  disp_oe;
    logic        u3_o;
    logic        u3_oe;
    logic        u1_o;
    logic        u1_oe;
    logic [1:0]  usb_o;
    logic [1:0]  usb_oe;
  } pfm_state_type;

  pfm_state_type st_r;
  pfm_state_type st_nxt;

  // Decoded selects of the current configuration.
  logic        card_gpio;
  logic        disp_gpio;
  logic        clk_osc;
  logic        usb_host;
  logic        u3_gpio;
  logic        u1_gpio;
  logic        rom_periph;
  logic        aux_periph;
  logic        req;
  logic [31:0] wmask;
  logic [15:0] sec_owned;
  logic [31:0] prim_owned;
  logic [3:0]  card_strobes;
  logic [3:0]  disp_strobes;

  // Field decode of the select register.
  assign card_gpio  = st_r.pinfunc[pfm_pkg::PFM_BIT_CARD];
  assign disp_gpio  = st_r.pinfunc[pfm_pkg::PFM_BIT_DISP];
  assign clk_osc    = st_r.pinfunc[pfm_pkg::PFM_BIT_CSRC];
  assign usb_host   = st_r.pinfunc[pfm_pkg::PFM_BIT_USB];
  assign u3_gpio    = st_r.pinfunc[pfm_pkg::PFM_BIT_U3];
  assign u1_gpio    = st_r.pinfunc[pfm_pkg::PFM_BIT_U1];
  assign rom_periph = st_r.pinfunc[pfm_pkg::PFM_BIT_ROM];
  assign aux_periph = st_r.pinfunc[pfm_pkg::PFM_BIT_AUX];

  // Peripheral strobes in pin order, highest line first.
  assign card_strobes = {card_attr_strobe_n, card_enable_low_n,
                         card_enable_high_n, card_write_strobe_n};
  assign disp_strobes = {ext_disp_read0, ext_disp_read1, ext_disp_write0, ext_disp_write1};

  // A bus request is live while cycle and strobe are both high.
  assign req   = wb_cyc_i & wb_stb_i;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Lines whose pin currently belongs to the general-purpose block.
  always_comb begin
    sec_owned = 16'h0000;
    sec_owned[pfm_pkg::PFM_SEC_DISP_LO +: 4] = {4{disp_gpio}};
    sec_owned[pfm_pkg::PFM_SEC_CARD_LO +: 4] = {4{card_gpio}};
    sec_owned[pfm_pkg::PFM_SEC_U1]           = u1_gpio;
    sec_owned[pfm_pkg::PFM_SEC_U3]           = u3_gpio;
    prim_owned = 32'hFFFF_FFFF;
    prim_owned[pfm_pkg::PFM_LINE_AUX] = ~aux_periph;
    prim_owned[pfm_pkg::PFM_LINE_ROM] = ~rom_periph;
  end

  // Next-state logic for registers, synchronisers, bus and pad drivers.
  always_comb begin
    st_nxt = st_r;

    // Pin inputs pass two flip-flops before any use.
    st_nxt.gin_s1 = pad_gpio_i;
    st_nxt.gin_s2 = st_r.gin_s1;
    st_nxt.sin_s1 = {1'b0, pad_u3_i, pad_u1_i, 5'h00, pad_card_i, pad_disp_i};
    st_nxt.sin_s2 = st_r.sin_s1;
    st_nxt.usb_s1 = pad_usb_i;
    st_nxt.usb_s2 = st_r.usb_s1;

    // Bus: ack follows one cycle after the request and drops the cycle after.
    st_nxt.ack = req & ~st_r.ack;
    if (req && !st_r.ack) begin
      // [R16] Register readback.
      if (wb_adr_i == pfm_pkg::PFM_OFS_PINFUNC) begin
        st_nxt.rdata = st_r.pinfunc & pfm_pkg::PFM_PINFUNC_MASK;
      end else if (wb_adr_i == pfm_pkg::PFM_OFS_GPIO_OUT) begin
        st_nxt.rdata = st_r.gpio_out;
      end else if (wb_adr_i == pfm_pkg::PFM_OFS_GPIO_DIR) begin
        st_nxt.rdata = st_r.gpio_dir;
      end else if (wb_adr_i == pfm_pkg::PFM_OFS_GPIO_IN) begin
        st_nxt.rdata = st_r.gin_s2 & prim_owned;
      end else begin
        st_nxt.rdata = 32'h0000_0000;
      end
    end

    // Writes take effect on the edge at which the master sees ack.
    if (req && st_r.ack && wb_we_i) begin
      if (wb_adr_i == pfm_pkg::PFM_OFS_PINFUNC) begin
        // [R5] Reserved bits kept zero.
        st_nxt.pinfunc = ((st_r.pinfunc & ~wmask) | (wb_dat_i & wmask))
                         & pfm_pkg::PFM_PINFUNC_MASK;
      end else if (wb_adr_i == pfm_pkg::PFM_OFS_GPIO_OUT) begin
        st_nxt.gpio_out = (st_r.gpio_out & ~wmask) | (wb_dat_i & wmask);
      end else if (wb_adr_i == pfm_pkg::PFM_OFS_GPIO_DIR) begin
        // [R3] Per-line direction.
        st_nxt.gpio_dir = (st_r.gpio_dir & ~wmask) | (wb_dat_i & wmask);
      end
    end

    // [R1] Default on runtime reset or sleep.
    if (runtime_reset || sleep_entry) begin
      st_nxt.pinfunc = pfm_pkg::PFM_PINFUNC_RST;
    end

    // [R3] Primary line drivers from software settings.
    st_nxt.gpio_o  = st_r.gpio_out;
    st_nxt.gpio_oe = st_r.gpio_dir;
    // [R13] ROM clock enable pin.
    if (rom_periph) begin
      st_nxt.gpio_o[pfm_pkg::PFM_LINE_ROM]  = sync_rom_clk_enable;
      st_nxt.gpio_oe[pfm_pkg::PFM_LINE_ROM] = 1'b1;
    end

    // [R6] Card pins: strobes or lines 207..204.
    if (card_gpio) begin
      st_nxt.card_o  = sec_gpio_do[pfm_pkg::PFM_SEC_CARD_LO +: 4];
      st_nxt.card_oe = sec_gpio_dir[pfm_pkg::PFM_SEC_CARD_LO +: 4];
    end else begin
      st_nxt.card_o  = card_strobes;
      st_nxt.card_oe = 4'hF;
    end

    // [R7] Display pins: strobes or lines 203..200.
    if (disp_gpio) begin
      st_nxt.disp_o  = sec_gpio_do[pfm_pkg::PFM_SEC_DISP_LO +: 4];
      st_nxt.disp_oe = sec_gpio_dir[pfm_pkg::PFM_SEC_DISP_LO +: 4];
    end else begin
      st_nxt.disp_o  = disp_strobes;
      st_nxt.disp_oe = 4'hF;
    end

    // [R10] Third serial transmit or line 214.
    if (u3_gpio) begin
      st_nxt.u3_o  = sec_gpio_do[pfm_pkg::PFM_SEC_U3];
      st_nxt.u3_oe = sec_gpio_dir[pfm_pkg::PFM_SEC_U3];
    end else begin
      st_nxt.u3_o  = third_serial_tx;
      st_nxt.u3_oe = 1'b1;
    end

    // [R12] Second serial transmit or line 213.
    if (u1_gpio) begin
      st_nxt.u1_o  = sec_gpio_do[pfm_pkg::PFM_SEC_U1];
      st_nxt.u1_oe = sec_gpio_dir[pfm_pkg::PFM_SEC_U1];
    end else begin
      st_nxt.u1_o  = second_serial_tx;
      st_nxt.u1_oe = 1'b1;
    end

    // [R9] USB pair routing.
    if (usb_host) begin
      st_nxt.usb_o  = host0_o;
      st_nxt.usb_oe = host0_oe;
    end else begin
      st_nxt.usb_o  = device_port_o;
      st_nxt.usb_oe = device_port_oe;
    end
  end

  // State register; clock enable low freezes everything but the auxiliary clock pin.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      // [R1] Hardware reset defaults.
      st_r          <= '0;
      // [R11] Bit 13 set.
      st_r.pinfunc  <= pfm_pkg::PFM_PINFUNC_RST;
      st_r.gpio_out <= pfm_pkg::PFM_GPIO_RST;
      st_r.gpio_dir <= pfm_pkg::PFM_GPIO_RST;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  // Bus outputs.
  assign wb_ack_o = st_r.ack;
  assign wb_dat_o = st_r.rdata;

  // [R4] Input levels for interrupt routing.
  assign gpio_in_level = st_r.gin_s2 & prim_owned;

  // [R2] Inputs reach only the function that owns the pin.
  assign sec_gpio_di   = st_r.sin_s2 & sec_owned;
  assign device_port_i = usb_host ? 2'b00 : st_r.usb_s2;
  assign host0_i       = usb_host ? st_r.usb_s2 : 2'b00;

  // Primary pads; the clock pin bypasses flops so the clock is not resampled.
  always_comb begin
    pad_gpio_o  = st_r.gpio_o;
    pad_gpio_oe = st_r.gpio_oe;
    // [R14] Auxiliary clock pin.
    if (aux_periph) begin
      // [R8] Clock source choice.
      pad_gpio_o[pfm_pkg::PFM_LINE_AUX]  = clk_osc ? osc32k_clk : aux_clock_out0;
      pad_gpio_oe[pfm_pkg::PFM_LINE_AUX] = 1'b1;
    end
  end

  // [R15] Pad drivers of the secondary and USB pins.
  assign pad_card_o  = st_r.card_o;
  assign pad_card_oe = st_r.card_oe;
  assign pad_disp_o  = st_r.disp_o;
  assign pad_disp_oe = st_r.disp_oe;
  assign pad_u3_o    = st_r.u3_o;
  assign pad_u3_oe   = st_r.u3_oe;
  assign pad_u1_o    = st_r.u1_o;
  assign pad_u1_oe   = st_r.u1_oe;
  assign pad_usb_o   = st_r.usb_o;
  assign pad_usb_oe  = st_r.usb_oe;

endmodule : pfm_pin_mux

//--- pkg/pfm_pkg.sv
// Constants for the primary pin function multiplexer.
//
// Notes on behaviour
// [R1] Select register returns to defaults on hardware reset, runtime reset and sleep.
// [R2] Each shared pin carries exactly one function at a time.
// [R3] Thirty-two primary lines, each individually an input or an output.
// [R4] Synchronised line inputs are offered to the interrupt controllers.
// [R5] Bits 31:19 read as zero; software writes them as zero.
// [R6] Bit 18 high gives lines 207..204 the card pins, low the card strobes.
// [R7] Bit 17 high gives lines 203..200 the display pins, low the display strobes.
// [R8] Bit 16 picks clock output 0 or the 32 kHz clock, only when bit 9 set.
// [R9] Bit 15 low routes the USB pair to device port, high to host port 0.
// [R10] Bit 14 high gives line 214 the pin, low the third serial transmit.
// [R11] Bit 13 is read/write, resets to one, and software writes it as one.
// [R12] Bit 12 high gives line 213 the pin, low the second serial transmit.
// [R13] Bit 11 low gives line 6 the pin, high the ROM clock enable.
// [R14] Bit 9 low gives line 2 the pin, high the selected clock.
// [R15] The unselected function's output and direction settings are ignored.
// [R16] Reads return last written read/write fields and zero for reserved fields.
package pfm_pkg;

  // Register byte offsets on the bus.
  localparam logic [7:0] PFM_OFS_PINFUNC  = 8'h00;
  localparam logic [7:0] PFM_OFS_GPIO_OUT = 8'h04;
  localparam logic [7:0] PFM_OFS_GPIO_DIR = 8'h08;
  localparam logic [7:0] PFM_OFS_GPIO_IN  = 8'h0C;

  // Field positions in the pin function select register.
  localparam int PFM_BIT_CARD = 18;
  localparam int PFM_BIT_DISP = 17;
  localparam int PFM_BIT_CSRC = 16;
  localparam int PFM_BIT_USB  = 15;
  localparam int PFM_BIT_U3   = 14;
  localparam int PFM_BIT_U1   = 12;
  localparam int PFM_BIT_ROM  = 11;
  localparam int PFM_BIT_AUX  = 9;

  // Primary lines that share pins with peripherals.
  localparam int PFM_LINE_AUX = 2;
  localparam int PFM_LINE_ROM = 6;

  // Reset value and the mask of implemented read/write bits.
  localparam logic [31:0] PFM_PINFUNC_RST  = 32'h0006_7000;
  localparam logic [31:0] PFM_PINFUNC_MASK = 32'h0007_FA00;
  localparam logic [31:0] PFM_GPIO_RST     = 32'h0000_0000;

  // Secondary line indices, counted from line 200.
  localparam int PFM_SEC_DISP_LO = 0;
  localparam int PFM_SEC_CARD_LO = 4;
  localparam int PFM_SEC_U1      = 13;
  localparam int PFM_SEC_U3      = 14;

endpackage : pfm_pkg

//--- verification/pfm_pin_mux_checker.sv
// Assertions for the primary pin function multiplexer.
`timescale 1ns/1ps
module pfm_pin_mux_checker (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        runtime_reset,
  input wire logic        sleep_entry,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [31:0] pad_gpio_o,
  input wire logic [3:0]  pad_card_oe,
  input wire logic        pad_u3_o,
  input wire logic        third_serial_tx,
  input wire logic [1:0]  pad_usb_o,
  input wire logic [1:0]  device_port_o,
  input wire logic [1:0]  host0_o,
  input wire logic        sync_rom_clk_enable,
  input wire logic        aux_clock_out0,
  input wire logic        osc32k_clk
);
  logic [31:0] sel_r;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Shadow of the select register; assumes whole-word writes.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_r <= pfm_pkg::PFM_PINFUNC_RST;
    end else if (runtime_reset || sleep_entry) begin
      sel_r <= pfm_pkg::PFM_PINFUNC_RST;
    end else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_adr_i == 8'h00) begin
      sel_r <= wb_dat_i & pfm_pkg::PFM_PINFUNC_MASK;
    end
  end
  ack_wait_a:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  ack_pulse_a:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  sel_read_a:
    assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h00 |-> wb_dat_o == sel_r)
      else $error("select readback wrong");
  card_drive_a:
    assert property ($past(!sel_r[18]) |-> pad_card_oe == 4'hF) else $error("card pins undriven");
  u3_tx_a:
    assert property ($past(!sel_r[14]) |-> pad_u3_o == $past(third_serial_tx))
      else $error("serial pin wrong");
  usb_route_a:
    assert property ($past(rst_n) |-> pad_usb_o == $past(sel_r[15] ? host0_o : device_port_o))
      else $error("usb routing wrong");
  rom_en_a:
    assert property ($past(sel_r[11]) |-> pad_gpio_o[6] == $past(sync_rom_clk_enable))
      else $error("rom enable pin wrong");
  aux_clk_a:
    assert property (sel_r[9] |-> pad_gpio_o[2] == (sel_r[16] ? osc32k_clk : aux_clock_out0))
      else $error("aux clock pin wrong");
endmodule : pfm_pin_mux_checker
bind pfm_pin_mux pfm_pin_mux_checker chk (.core_clk(core_clk), .rst_n(rst_n),
  .runtime_reset(runtime_reset), .sleep_entry(sleep_entry), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pad_gpio_o(pad_gpio_o), .pad_card_oe(pad_card_oe),
  .pad_u3_o(pad_u3_o), .third_serial_tx(third_serial_tx), .pad_usb_o(pad_usb_o),
  .device_port_o(device_port_o), .host0_o(host0_o), .sync_rom_clk_enable(sync_rom_clk_enable),
  .aux_clock_out0(aux_clock_out0), .osc32k_clk(osc32k_clk));

//--- verification/pfm_pad_model.sv
// Pin-level model of the external devices wired to the shared pins.
`timescale 1ns/1ps
module pfm_pad_model #(parameter int W = 44) (
  input  wire logic         core_clk,
  input  wire logic [W-1:0] pin_o,
  input  wire logic [W-1:0] pin_oe,
  input  wire logic [W-1:0] ext_val,
  input  wire logic [W-1:0] ext_en,
  output logic      [W-1:0] pin_i
);
  logic [W-1:0] flt_r = '0;
  // An undriven pin toggles each cycle, so a stale level never reads back.
  always_ff @(posedge core_clk) flt_r <= ~flt_r;
  // The block's drive wins, then the device's, then the floating pattern.
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ((ext_en & ext_val) | (~ext_en & flt_r)));
endmodule : pfm_pad_model

//--- verification/test_primary_pin_function_mux.sv
// Self-checking bench for the primary pin function multiplexer.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module test_primary_pin_function_mux;
  localparam logic [31:0] GOUT = 32'hA5A5_5A5A;
  localparam logic [31:0] GDIR = 32'h0000_FFFF;
  localparam logic [43:0] EXT  = 44'h009_3C3C_0000;
  int n_fail = 0;
  int checks_done = 0;
  logic core_clk = 1'b0, rst_n = 1'b0, rrst = 1'b0, slp = 1'b0, cyc = 1'b0, stb = 1'b0;
  logic we = 1'b0, osc = 1'b0, aux = 1'b1, rom = 1'b0, tx3 = 1'b0, tx1 = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000, q;
  logic [15:0] sdo = 16'h6A5C, sdir = 16'h200F;
  logic [3:0]  cs = 4'h6, ds = 4'hA;
  logic [1:0]  dpo = 2'h2, dpoe = 2'h3, h0o = 2'h1, h0oe = 2'h2;
  wire  [43:0] po, poe, pi;
  wire  [31:0] lvl, rd;
  wire  [15:0] sdi;
  wire  [1:0]  dpi, h0i;
  wire         ack;
  wire  [27:0] pads = {po[2], poe[2], po[6], poe[6], po[43:42], poe[43:42], po[41], poe[41],
                       po[40], poe[40], po[39:36], poe[39:36], po[35:32], poe[35:32]};
  always #5 core_clk = ~core_clk;
  pfm_pin_mux DUT (.core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1), .runtime_reset(rrst),
    .sleep_entry(slp), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack), .pad_gpio_i(pi[31:0]),
    .pad_gpio_o(po[31:0]), .pad_gpio_oe(poe[31:0]), .gpio_in_level(lvl), .sec_gpio_do(sdo),
    .sec_gpio_dir(sdir), .sec_gpio_di(sdi), .pad_card_i(pi[35:32]), .pad_card_o(po[35:32]),
    .pad_card_oe(poe[35:32]), .card_attr_strobe_n(cs[3]), .card_enable_low_n(cs[2]),
    .card_enable_high_n(cs[1]), .card_write_strobe_n(cs[0]), .pad_disp_i(pi[39:36]),
    .pad_disp_o(po[39:36]), .pad_disp_oe(poe[39:36]), .ext_disp_read0(ds[3]),
    .ext_disp_read1(ds[2]), .ext_disp_write0(ds[1]), .ext_disp_write1(ds[0]),
    .pad_u3_i(pi[40]), .pad_u3_o(po[40]), .pad_u3_oe(poe[40]), .third_serial_tx(tx3),
    .pad_u1_i(pi[41]), .pad_u1_o(po[41]), .pad_u1_oe(poe[41]), .second_serial_tx(tx1),
    .pad_usb_i(pi[43:42]), .pad_usb_o(po[43:42]), .pad_usb_oe(poe[43:42]),
    .device_port_o(dpo), .device_port_oe(dpoe), .device_port_i(dpi), .host0_o(h0o),
    .host0_oe(h0oe), .host0_i(h0i), .sync_rom_clk_enable(rom), .aux_clock_out0(aux),
    .osc32k_clk(osc));
  pfm_pad_model #(.W(44)) ext (.core_clk(core_clk), .pin_o(po), .pin_oe(poe), .ext_val(EXT),
    .ext_en(44'h0FF_FFFF_FFFF), .pin_i(pi));
  // One classic cycle: hold the request until ack is sampled, then release.
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge core_clk);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    do begin
      @(posedge core_clk);
    end while (ack !== 1'b1);
    q = rd;
    {cyc, stb} <= 2'b00;
  endtask : bus
  // Expected pin drive for one select value.
  function automatic logic [27:0] expv(input logic [31:0] c);
    return {c[9] ? {c[16] ? osc : aux, 1'b1} : {GOUT[2], GDIR[2]},
            c[11] ? {rom, 1'b1} : {GOUT[6], GDIR[6]}, c[15] ? {h0o, h0oe} : {dpo, dpoe},
            c[12] ? {sdo[13], sdir[13]} : {tx1, 1'b1}, c[14] ? {sdo[14], sdir[14]} : {tx3, 1'b1},
            c[17] ? {sdo[3:0], sdir[3:0]} : {ds, 4'hF}, c[18] ? {sdo[7:4], sdir[7:4]} : {cs, 4'hF}};
  endfunction : expv
  task automatic t_regs;
    bus(8'h00, 1'b0, 32'h0);
    `CHK("pinfunc reset", pfm_pkg::PFM_PINFUNC_RST, q)
    bus(8'h00, 1'b1, 32'h0007_FFFF);
    bus(8'h00, 1'b0, 32'h0);
    `CHK("pinfunc ro", pfm_pkg::PFM_PINFUNC_MASK, q)
    bus(8'h10, 1'b0, 32'h0);
    `CHK("unmapped", 32'h0, q)
  endtask : t_regs
  task automatic t_mux;
    logic [31:0] cfg [5] = '{32'h0000_2000, 32'h0007_FA00, 32'h0001_AA00, 32'h0000_2200,
                             32'h0006_7000};
    bus(8'h04, 1'b1, GOUT);
    bus(8'h08, 1'b1, GDIR);
    foreach (cfg[i]) begin
      bus(8'h00, 1'b1, cfg[i]);
      repeat (3) @(posedge core_clk);
      #1;
      `CHK("pads", expv(cfg[i]), pads)
      `CHK("card in", cfg[i][18] ? EXT[35:32] : 4'h0, sdi[7:4])
      `CHK("usb dev in", cfg[i][15] ? 2'b00 : dpo, dpi)
    end
    `CHK("usb host in", 2'b00, h0i)
    `CHK("gpio out", GOUT[15:0], po[15:0])
    `CHK("gpio level", EXT[31:16], lvl[31:16])
    bus(8'h0C, 1'b0, 32'h0);
    `CHK("gpio in", EXT[31:16], q[31:16])
  endtask : t_mux
  task automatic t_wake;
    for (int k = 0; k < 2; k++) begin
      bus(8'h00, 1'b1, 32'h0000_2000);
      @(posedge core_clk);
      {slp, rrst} <= k ? 2'b10 : 2'b01;
      @(posedge core_clk);
      {slp, rrst} <= 2'b00;
      bus(8'h00, 1'b0, 32'h0);
      `CHK("pinfunc wake", pfm_pkg::PFM_PINFUNC_RST, q)
      bus(8'h04, 1'b0, 32'h0);
      `CHK("gpio kept", GOUT, q)
    end
  endtask : t_wake
  task automatic final_report;
    if (n_fail == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report
  // Main sequence.
  initial begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    t_regs();
    t_mux();
    t_wake();
    final_report();
  end
  // Watchdog.
  initial begin
    #100000;
    n_fail++;
    final_report();
  end
endmodule : test_primary_pin_function_mux
